// ### hdl/sdrpin_pkg.sv
// Purpose: constants for the sdram command pin interface
// Assumes: x16 organization, four banks, thirteen row bits
// Notes:   timing counts are in clock cycles
package sdrpin_pkg;
  localparam int ROW_W       = 13;
  localparam int COL_W       = 9;
  localparam int BANK_W      = 2;
  localparam int DATA_W      = 16;
  localparam int NUM_BANKS   = 4;
  localparam int PRE_BIT     = 10;
  localparam int MASK_LAT    = 2;
  localparam int LOW_LANE_LO = 0;
  localparam int HIGH_LANE_LO = 8;
  localparam int LANE_W      = 8;
  localparam int MEM_AW      = 8;
  localparam int BURST_LEN   = 4;
  localparam logic [3:0] CMD_NOP    = 4'h7;
  localparam logic [3:0] CMD_ACT    = 4'h3;
  localparam logic [3:0] CMD_READ   = 4'h5;
  localparam logic [3:0] CMD_WRITE  = 4'h4;
  localparam logic [3:0] CMD_PRE    = 4'h2;
  localparam logic [3:0] CMD_REF    = 4'h1;
  localparam logic [3:0] CMD_LMR    = 4'h0;
  localparam logic [14:0] MODE_RST  = 15'h0000;
endpackage

// ### hdl/sdram_pin_core.sv
// Purpose: device-side command pins, masks and data lanes of an sdram
// Assumes: x16 part, shallow internal array, fixed burst of four
// Notes:   command bits are {sel, row, col, wr}, all active low
//
// Overview of operation
// [R01] all inputs sampled on rising clock edge
// [R02] burst counter and outputs advance on clock
// [R03] gate low picks power-down, refresh or suspend
// [R04] gate synchronous except inside power-down modes; the code samples it on the rising edge in every mode
// [R05] receivers off during power-down and self refresh
// [R06] controller may tie clock gate high
// [R07] commands decoded only when select low
// [R08] bursts and masks continue while deselected
// [R09] select and strobes jointly encode command
// [R10] write lane masked high is not stored
// [R11] read mask high tristates two clocks later
// [R12] lower mask low byte, upper high byte
// [R13] bank select picks bank, carries opcode
// [R14] active captures thirteen-bit row address
// [R15] read or write takes column bits
// [R16] address bit ten selects auto precharge
// [R17] precharge bit ten high closes all banks
// [R18] mode load takes opcode from address, bank
`timescale 1ns/1ps
module sdrpin_core
  import sdrpin_pkg::*;
(
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst,
  // control
  input  wire logic                clkGate,
  input  wire logic                selectN,
  input  wire logic                rowStrobeN,
  input  wire logic                colStrobeN,
  input  wire logic                writeStrobeN,
  // masks and address
  input  wire logic                lower_byte_mask,
  input  wire logic                upper_byte_mask,
  input  wire logic [BANK_W-1:0]   bank_select,
  input  wire logic [ROW_W-1:0]    addr_in,
  // data lines
  input  wire logic [DATA_W-1:0]   data_lines_in,
  output logic      [DATA_W-1:0]   data_lines_out,
  output logic      [1:0]          data_lines_oe_n,
  // status
  output logic      [NUM_BANKS-1:0] bankOpen,
  output logic      [14:0]          modeWord,
  output logic      [2:0]           lowPowerState
);
  // ==========================================================
  // state
  typedef enum logic [4:0] {
    SDR_RUN   = 5'b00001,
    SDR_IPD   = 5'b00010,
    SDR_APD   = 5'b00100,
    SDR_SREF  = 5'b01000,
    SDR_SUSP  = 5'b10000
  } sdrpin_pwr_t;

  sdrpin_pwr_t                pwr;
  sdrpin_pwr_t                next_pwr;
  logic [3:0]                 cmd;
  logic                       awake;
  logic                       decodeOk;
  logic [ROW_W-1:0]           openRow [NUM_BANKS];
  logic [DATA_W-1:0]          mem [2**MEM_AW];
  logic [COL_W-1:0]           col;
  logic [BANK_W-1:0]          burstBank;
  logic [2:0]                 beatsLeft;
  logic                       burstWrite;
  logic                       autoPre;
  logic [1:0]                 readPipe [MASK_LAT];
  logic [1:0]                 maskNow;
  logic                       readBeat;
  logic                       anyOpen;
  logic                       inBurst;

  function automatic logic [MEM_AW-1:0] memIndex(
    input logic [BANK_W-1:0] b,
    input logic [COL_W-1:0]  c);
    memIndex = {b, c[MEM_AW-BANK_W-1:0]};
  endfunction

  // ==========================================================
  // command decode
  assign cmd      = {selectN, rowStrobeN, colStrobeN, writeStrobeN}; // [R09]
  assign awake    = (pwr == SDR_RUN);
  assign decodeOk = awake && clkGate && !selectN; // [R07] [R05]
  assign maskNow  = {upper_byte_mask, lower_byte_mask}; // [R12]
  assign anyOpen  = |bankOpen;
  assign inBurst  = beatsLeft != 3'h0;

  // ==========================================================
  // low power selection
  always_comb begin
    next_pwr = pwr;
    unique case (pwr)
      SDR_RUN: begin
        if (!clkGate) begin // [R03] [R04]
          if (inBurst)
            next_pwr = SDR_SUSP;
          else if (anyOpen)
            next_pwr = SDR_APD;
          else if (cmd == CMD_REF)
            next_pwr = SDR_SREF;
          else
            next_pwr = SDR_IPD;
        end
      end
      SDR_IPD, SDR_APD, SDR_SREF, SDR_SUSP: begin
        if (clkGate)
          next_pwr = SDR_RUN; // [R04]
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst)
      pwr <= SDR_RUN;
    else
      pwr <= next_pwr; // [R01]
  end

  always_comb begin
    unique case (pwr)
      SDR_IPD:  lowPowerState = 3'h1;
      SDR_APD:  lowPowerState = 3'h2;
      SDR_SREF: lowPowerState = 3'h3;
      SDR_SUSP: lowPowerState = 3'h4;
      default:  lowPowerState = 3'h0;
    endcase
  end

  // ==========================================================
  // bank and mode tracking
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bankOpen <= '0;
      modeWord <= MODE_RST;
      for (int i = 0; i < NUM_BANKS; i++)
        openRow[i] <= '0;
    end else begin
      if (awake && beatsLeft == 3'h1 && autoPre)
        bankOpen[burstBank] <= 1'b0; // [R16]
      if (decodeOk && cmd == CMD_ACT) begin
        bankOpen[bank_select] <= 1'b1; // [R13]
        openRow[bank_select]  <= addr_in; // [R14]
      end
      if (decodeOk && cmd == CMD_PRE) begin
        if (addr_in[PRE_BIT])
          bankOpen <= '0; // [R17]
        else
          bankOpen[bank_select] <= 1'b0; // [R17]
      end
      if (decodeOk && cmd == CMD_LMR)
        modeWord <= {bank_select, addr_in}; // [R18]
    end
  end

  // ==========================================================
  // burst engine
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      col        <= '0;
      burstBank  <= '0;
      beatsLeft  <= '0;
      burstWrite <= 1'b0;
      autoPre    <= 1'b0;
    end else if (decodeOk && (cmd == CMD_READ || cmd == CMD_WRITE)) begin
      col        <= addr_in[COL_W-1:0]; // [R15]
      burstBank  <= bank_select; // [R13]
      autoPre    <= addr_in[PRE_BIT]; // [R16]
      burstWrite <= (cmd == CMD_WRITE);
      beatsLeft  <= 3'(BURST_LEN);
    end else if (awake && inBurst) begin
      col       <= col + 9'h001; // [R02] [R08]
      beatsLeft <= beatsLeft - 3'h1;
    end
  end

  // ==========================================================
  // write lanes
  always_ff @(posedge ref_clk) begin
    if (awake && inBurst && burstWrite) begin
      if (!lower_byte_mask) // [R10]
        mem[memIndex(burstBank, col)][LOW_LANE_LO +: LANE_W] <=
          data_lines_in[LOW_LANE_LO +: LANE_W];
      if (!upper_byte_mask) // [R10]
        mem[memIndex(burstBank, col)][HIGH_LANE_LO +: LANE_W] <=
          data_lines_in[HIGH_LANE_LO +: LANE_W];
    end
  end

  // ==========================================================
  // read data and output mask pipeline
  assign readBeat = awake && inBurst && !burstWrite;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      readPipe[0] <= 2'h3;
      readPipe[1] <= 2'h3;
    end else begin
      readPipe[0] <= maskNow | {2{!readBeat}}; // [R11] [R08]
      readPipe[1] <= readPipe[0]; // [R11]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst)
      data_lines_out <= '0;
    else if (readBeat)
      data_lines_out <= mem[memIndex(burstBank, col)]; // [R02]
  end

  assign data_lines_oe_n = readPipe[MASK_LAT-1]; // [R11] [R12]

  // ==========================================================
  // checks
  sequence s_no_beat;
    !readBeat ##2 1'b1;
  endsequence
  sequence s_burst_start;
    decodeOk && (cmd == CMD_READ || cmd == CMD_WRITE);
  endsequence
  sequence s_burst_load;
    beatsLeft == 3'(BURST_LEN) && col == $past(addr_in[COL_W-1:0]);
  endsequence
  a_mask_latency: assert property ( // [R11]
    @(posedge ref_clk) disable iff (rst)
    s_no_beat |-> data_lines_oe_n == 2'h3)
    else $error("output enabled without a read two clocks before");
  a_mask_high: assert property ( // [R11]
    @(posedge ref_clk) disable iff (rst)
    (readBeat && upper_byte_mask) |-> ##2 data_lines_oe_n[1])
    else $error("upper mask did not tristate high byte");
  a_mask_low: assert property ( // [R12]
    @(posedge ref_clk) disable iff (rst)
    (readBeat && lower_byte_mask) |-> ##2 data_lines_oe_n[0])
    else $error("lower mask did not tristate low byte");
  a_deselect_ignore: assert property ( // [R07]
    @(posedge ref_clk) disable iff (rst)
    (selectN && awake && !inBurst) |=> $stable(bankOpen))
    else $error("bank state changed while deselected");
  a_burst_continue: assert property ( // [R08]
    @(posedge ref_clk) disable iff (rst)
    (awake && clkGate && inBurst && selectN) |=>
      beatsLeft == $past(beatsLeft) - 3'h1)
    else $error("burst stalled while deselected");
  a_burst_load: assert property ( // [R15]
    @(posedge ref_clk) disable iff (rst)
    s_burst_start |=> s_burst_load)
    else $error("burst start column not taken");
  a_burst_bank: assert property ( // [R13] [R16]
    @(posedge ref_clk) disable iff (rst)
    s_burst_start |=> burstBank == $past(bank_select) &&
      autoPre == $past(addr_in[PRE_BIT]))
    else $error("burst bank or auto precharge not taken");
  a_burst_end: assert property ( // [R02]
    @(posedge ref_clk) disable iff (rst)
    (awake && beatsLeft == 3'h1 &&
      !(decodeOk && (cmd == CMD_READ || cmd == CMD_WRITE))) |=> !inBurst)
    else $error("burst ran past its last beat");
  a_auto_close: assert property ( // [R16]
    @(posedge ref_clk) disable iff (rst)
    (awake && beatsLeft == 3'h1 && autoPre && !(decodeOk && cmd == CMD_ACT))
      |=> !bankOpen[$past(burstBank)])
    else $error("auto precharge left the bank open");
  a_act_opens: assert property ( // [R13]
    @(posedge ref_clk) disable iff (rst)
    (decodeOk && cmd == CMD_ACT) |=> bankOpen[$past(bank_select)])
    else $error("active did not open bank");
  a_row_capture: assert property ( // [R14]
    @(posedge ref_clk) disable iff (rst)
    (decodeOk && cmd == CMD_ACT) |=>
      openRow[$past(bank_select)] == $past(addr_in))
    else $error("active did not capture the row");
  a_pre_all: assert property ( // [R17]
    @(posedge ref_clk) disable iff (rst)
    (decodeOk && cmd == CMD_PRE && addr_in[PRE_BIT]) |=> !anyOpen)
    else $error("precharge all left a bank open");
  a_pre_one: assert property ( // [R17]
    @(posedge ref_clk) disable iff (rst)
    (decodeOk && cmd == CMD_PRE && !addr_in[PRE_BIT]) |=>
      !bankOpen[$past(bank_select)])
    else $error("single precharge left its bank open");
  a_mode_load: assert property ( // [R18]
    @(posedge ref_clk) disable iff (rst)
    (decodeOk && cmd == CMD_LMR) |=>
      modeWord == {$past(bank_select), $past(addr_in)})
    else $error("mode word not loaded");
  a_lane_kept: assert property ( // [R10]
    @(posedge ref_clk) disable iff (rst)
    (awake && inBurst && burstWrite && lower_byte_mask) |=>
      mem[$past(memIndex(burstBank, col))][LOW_LANE_LO +: LANE_W] ==
      $past(mem[memIndex(burstBank, col)][LOW_LANE_LO +: LANE_W]))
    else $error("masked low lane was stored");
  a_lane_stored: assert property ( // [R10]
    @(posedge ref_clk) disable iff (rst)
    (awake && inBurst && burstWrite && !upper_byte_mask) |=>
      mem[$past(memIndex(burstBank, col))][HIGH_LANE_LO +: LANE_W] ==
      $past(data_lines_in[HIGH_LANE_LO +: LANE_W]))
    else $error("unmasked high lane was not stored");
  a_suspend_enter: assert property ( // [R03]
    @(posedge ref_clk) disable iff (rst)
    (awake && !clkGate && inBurst) |=> pwr == SDR_SUSP)
    else $error("clock suspend not entered during burst");
  a_apd_enter: assert property ( // [R03]
    @(posedge ref_clk) disable iff (rst)
    (awake && !clkGate && !inBurst && anyOpen) |=> pwr == SDR_APD)
    else $error("active power-down not entered");
  a_sref_enter: assert property ( // [R03]
    @(posedge ref_clk) disable iff (rst)
    (awake && !clkGate && !inBurst && !anyOpen && cmd == CMD_REF) |=>
      pwr == SDR_SREF)
    else $error("self refresh not entered");
  a_sleep_hold: assert property ( // [R05]
    @(posedge ref_clk) disable iff (rst)
    (pwr == SDR_SREF && !clkGate) |=>
      $stable(bankOpen) && $stable(modeWord))
    else $error("state changed while receivers off");
  a_frozen_state: assert property ( // [R05]
    @(posedge ref_clk) disable iff (rst)
    !awake |=> $stable(beatsLeft) && $stable(bankOpen) && $stable(modeWord))
    else $error("state moved in a low power mode");
  a_wake: assert property ( // [R04]
    @(posedge ref_clk) disable iff (rst)
    (!awake && clkGate) |=> awake)
    else $error("gate high did not leave low power");
endmodule

// ### bench/sdrpin_ctl_model.sv
// Purpose: behavioural memory controller facing the sdram pins
// Assumes: commands launched 1 ns after a rising edge, held one cycle
// Notes:   released write data shows the inverse of its last value
`timescale 1ns/1ps
module sdrpin_ctl_model
  import sdrpin_pkg::*;
(
  // clock
  input  wire logic                  ref_clk,
  // command side
  output logic                       clkGate,
  output logic       [3:0]           cmdPins,
  output logic       [BANK_W-1:0]    bankSel,
  output logic       [ROW_W-1:0]     addrBus,
  // data side
  output logic       [1:0]           masks,
  output logic       [DATA_W-1:0]    wrData
);
  // ==========================================================
  // idle levels
  initial begin
    clkGate = 1'b1;
    cmdPins = 4'hf;
    bankSel = '0;
    addrBus = '0;
    masks   = 2'h0;
    wrData  = 16'h0000;
  end

  // ==========================================================
  // one command, then the idle command (nop unless given) on the following edge
  task automatic send(input logic [3:0] c, input logic [1:0] b,
                      input logic [12:0] a,
                      input logic [3:0] idle = CMD_NOP);
    @(posedge ref_clk);
    #1;
    cmdPins = c;
    bankSel = b;
    addrBus = a;
    @(posedge ref_clk);
    #1;
    cmdPins = idle;
  endtask

  // gate low together with a command on one edge
  task automatic doze(input logic [3:0] c);
    @(posedge ref_clk);
    #1;
    clkGate = 1'b0;
    cmdPins = c;
    @(posedge ref_clk);
    #1;
    cmdPins = CMD_NOP;
  endtask

  // write data released after a burst
  task automatic drop();
    wrData = ~wrData;
  endtask

  // data and masks for the next edge
  task automatic put(input logic [15:0] d, input logic [1:0] m);
    wrData = d;
    masks  = m;
  endtask

  task automatic gate(input logic v);
    @(posedge ref_clk);
    #1;
    clkGate = v;
  endtask
endmodule

// ### bench/sdram_command_pin_interface_test.sv
// Purpose: self-checking bench for the sdram command pin core
// Assumes: burst of four, x16 lanes, registered outputs
// Notes:   inputs change 1 ns after each rising edge
`timescale 1ns/1ps
module sdram_command_pin_interface_test;
  import sdrpin_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clkGate;
  logic [3:0] cmdPins;
  logic [1:0] bankSel, masks, oeN;
  logic [12:0] addrBus;
  logic [15:0] wrData, rdData;
  logic [3:0] bankOpen;
  logic [14:0] modeWord;
  logic [2:0] lowPowerState;
  int err_total = 0;
  int checks = 0;

  always #12.5 ref_clk = ~ref_clk;

  sdrpin_ctl_model ctl_i (.ref_clk(ref_clk), .clkGate(clkGate),
    .cmdPins(cmdPins), .bankSel(bankSel), .addrBus(addrBus),
    .masks(masks), .wrData(wrData));
  sdrpin_core sdrpin_core_i (.ref_clk(ref_clk), .rst(rst),
    .clkGate(clkGate), .selectN(cmdPins[3]),
    .rowStrobeN(cmdPins[2]), .colStrobeN(cmdPins[1]),
    .writeStrobeN(cmdPins[0]), .lower_byte_mask(masks[0]),
    .upper_byte_mask(masks[1]), .bank_select(bankSel),
    .addr_in(addrBus), .data_lines_in(wrData),
    .data_lines_out(rdData), .data_lines_oe_n(oeN),
    .bankOpen(bankOpen), .modeWord(modeWord),
    .lowPowerState(lowPowerState));

  // ==========================================================
  // helpers
  function automatic bit ok(input bit c);
    checks++;
    return c;
  endfunction
  task automatic miss(input string m);
    err_total++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_mode();
    if (!ok(oeN === 2'h3 && bankOpen === 4'h0)) miss("reset state");
    ctl_i.send(CMD_LMR, 2'h2, 13'h0a5a);
    if (!ok(modeWord === 15'h4a5a)) miss("mode word");
    ctl_i.send({1'b1, CMD_ACT[2:0]}, 2'h2, 13'h0000);
    if (!ok(bankOpen === 4'h0)) miss("deselected act");
    ctl_i.send(CMD_ACT, 2'h1, 13'h1fff);
    if (!ok(bankOpen === 4'h2)) miss("act bank one");
  endtask

  task automatic t_burst();
    ctl_i.send(CMD_WRITE, 2'h1, 13'h0005);
    for (int k = 0; k < 4; k++) begin
      ctl_i.put(16'ha0a0 + 16'(k), 2'h0);
      tick();
    end
    ctl_i.drop();
    ctl_i.send(CMD_WRITE, 2'h1, 13'h0005);
    for (int k = 0; k < 4; k++) begin
      ctl_i.put(16'h5b00 + 16'(k), (k == 0) ? 2'h1 : 2'h0);
      tick();
    end
    ctl_i.drop();
    ctl_i.send(CMD_READ, 2'h1, 13'h0405, 4'hf);
    for (int e = 1; e < 7; e++) begin
      ctl_i.put(16'ha4fc, (e == 2) ? 2'h2 : 2'h0);
      tick();
      if (e == 1 && !ok(rdData === 16'h5ba0)) miss("masked lane");
      if (e > 1 && e < 5 && !ok(rdData === 16'h5b00 + 16'(e - 1)))
        miss("read beat");
      if (e > 2 && !ok(oeN === ((e == 3) ? 2'h2 : (e == 6) ? 2'h3 : 2'h0)))
        miss("output enable");
    end
    if (!ok(bankOpen === 4'h0)) miss("auto precharge");
  endtask

  task automatic t_power();
    ctl_i.send(CMD_ACT, 2'h0, 13'h0001);
    ctl_i.send(CMD_ACT, 2'h3, 13'h0002);
    ctl_i.send(CMD_PRE, 2'h0, 13'h0000);
    if (!ok(bankOpen === 4'h8)) miss("single precharge");
    ctl_i.gate(1'b0);
    tick();
    if (!ok(lowPowerState === 3'h2)) miss("active pd");
    ctl_i.send(CMD_ACT, 2'h0, 13'h0003);
    if (!ok(bankOpen === 4'h8)) miss("act in pd");
    ctl_i.gate(1'b1);
    tick();
    if (!ok(lowPowerState === 3'h0)) miss("pd exit");
    ctl_i.send(CMD_PRE, 2'h1, 13'h0400);
    if (!ok(bankOpen === 4'h0)) miss("precharge all");
    ctl_i.gate(1'b0);
    tick();
    if (!ok(lowPowerState === 3'h1)) miss("idle pd");
    ctl_i.gate(1'b1);
  endtask

  task automatic t_sleep();
    ctl_i.send(CMD_WRITE, 2'h2, 13'h0010);
    ctl_i.gate(1'b0);
    tick();
    if (!ok(lowPowerState === 3'h4)) miss("clock suspend");
    ctl_i.gate(1'b1);
    tick();
    if (!ok(lowPowerState === 3'h0)) miss("suspend exit");
    repeat (2) tick();
    ctl_i.doze(CMD_REF);
    if (!ok(lowPowerState === 3'h3)) miss("self refresh");
    ctl_i.send(CMD_LMR, 2'h0, 13'h0123);
    if (!ok(modeWord === 15'h4a5a)) miss("load in refresh");
    ctl_i.gate(1'b1);
    tick();
    if (!ok(lowPowerState === 3'h0)) miss("refresh exit");
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (5) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    t_mode();
    t_burst();
    t_power();
    t_sleep();
    wrap_up();
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    miss("run timed out");
    wrap_up();
  end
endmodule
